// file: uedc_map.vh
// Register map constants for the echo/drive control register slice.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef UEDC_MAP_VH
`define UEDC_MAP_VH

// Register addresses (SPI byte address space)
`define UEDC_ADDR_ECHO_INT    8'h17
`define UEDC_ADDR_ZERO_CROSS  8'h18
`define UEDC_ADDR_DRV_CLAMP   8'h19
`define UEDC_ADDR_BURST_LEN   8'h1A
`define UEDC_ADDR_PWR_TRIG    8'h1B
`define UEDC_ADDR_STATUS      8'h1C
`define UEDC_ADDR_PART_ID     8'h1D

// Reset values
`define UEDC_RST_ECHO_INT     8'h07
`define UEDC_RST_ZERO_CROSS   8'h14
`define UEDC_RST_DRV_CLAMP    8'h00
`define UEDC_RST_BURST_LEN    8'h00
`define UEDC_RST_PWR_TRIG     8'h00

// Writable bit masks; everything else is reserved or read-only
`define UEDC_WMASK_ECHO_INT   8'h1F
`define UEDC_WMASK_ZERO_CROSS 8'hFF
`define UEDC_WMASK_DRV_CLAMP  8'h3F
`define UEDC_WMASK_BURST_LEN  8'hBF
`define UEDC_WMASK_PWR_TRIG   8'hC3

// Field positions
`define UEDC_BIT_ECHO_EN      4
`define UEDC_BIT_ZC_EN        7
`define UEDC_BIT_ZC_GATE      6
`define UEDC_BIT_ZC_INSEL     5
`define UEDC_BIT_HALF_BRG     7
`define UEDC_BIT_SLEEP        7
`define UEDC_BIT_STANDBY      6
`define UEDC_BIT_CHG_TRIG     1
`define UEDC_BIT_BURST_TRIG   0
`define UEDC_IO_MODE_0        2'h0
`define UEDC_DT_DISABLED      3'h7

// Deglitch limits in 5 ns clock cycles: 64, 48, 32, 24, 16, 8 and 4 us
`define UEDC_DT0_CYC          15'h3200
`define UEDC_DT1_CYC          15'h2580
`define UEDC_DT2_CYC          15'h1900
`define UEDC_DT3_CYC          15'h12C0
`define UEDC_DT4_CYC          15'h0C80
`define UEDC_DT5_CYC          15'h0640
`define UEDC_DT6_CYC          15'h0320

`endif

// file: uedc_stuck_timer.v
// Driver stuck-state timer: measures time since the last edge on the
// driver input during burst mode. Inputs are already synchronised.
`timescale 1ns/1ps
`include "uedc_map.vh"

module uedc_stuck_timer #(
	parameter [14:0] DT0_CYC = `UEDC_DT0_CYC,
	parameter [14:0] DT1_CYC = `UEDC_DT1_CYC,
	parameter [14:0] DT2_CYC = `UEDC_DT2_CYC,
	parameter [14:0] DT3_CYC = `UEDC_DT3_CYC,
	parameter [14:0] DT4_CYC = `UEDC_DT4_CYC,
	parameter [14:0] DT5_CYC = `UEDC_DT5_CYC,
	parameter [14:0] DT6_CYC = `UEDC_DT6_CYC
) (
	input  wire       clk_sys_in,
	input  wire       rst_n_in,
	input  wire       active_in,
	input  wire       toggle_in,
	input  wire [2:0] code_in,
	output reg        stuck_out
);

	reg  [14:0] count_reg;
	reg  [14:0] limit;

	// Deglitch code to cycle limit
	always @* begin
		case (code_in)
			3'h0: limit = DT0_CYC;
			3'h1: limit = DT1_CYC;
			3'h2: limit = DT2_CYC;
			3'h3: limit = DT3_CYC;
			3'h4: limit = DT4_CYC;
			3'h5: limit = DT5_CYC;
			3'h6: limit = DT6_CYC;
			default: limit = 15'h7FFF;
		endcase
	end

	// Counter restarts on every edge; pulse when the limit is passed
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_reg <= 15'h0000;
			stuck_out <= 1'b0;
		end else begin
			stuck_out <= 1'b0;
			if (!active_in || toggle_in) begin
				count_reg <= 15'h0000;
			end else if (count_reg != 15'h7FFF) begin
				count_reg <= count_reg + 15'h0001;
			end
			if (active_in && !toggle_in && code_in != `UEDC_DT_DISABLED && count_reg == limit) begin
				stuck_out <= 1'b1;
			end
		end
	end

endmodule // uedc_stuck_timer

// file: uedc_regs.v
// Control and status register slice of the ultrasonic echo/drive front end.
// Assumes a byte-wide register port from the serial interface decoder on
// the same clock, and analog status levels arriving from other domains.
// Assumes the IO mode, deglitch code and supply settings held in registers
// outside this slice arrive as same-clock levels, so they are not synchronised.
// Limitation: the sticky fault bits have no software clear because the status
// register is read-only; only a device reset returns them to zero.
// Every output comes straight from a flip-flop, so pins and analog settings
// change one edge after the register copy that feeds them.
// Widths are fixed; only the identification value is a parameter.
//
// Contract
// - Echo interrupt pin shows comparator result only while echo enable bit set.
// - Four-bit echo threshold code, reset 0x7, passed to analog comparator.
// - Zero-cross comparator enabled only by bit 7, reset zero.
// - With gating bit set, zero-cross output only while echo detected.
// - Bit 5 selects zero-cross input: common mode or negative input.
// - Two-bit zero-cross stage select in bits 4:3, reset 0x2.
// - Three-bit hysteresis code, reset 0x4, passed to analog comparator.
// - Six-bit drive current clamp code, reset zero.
// - Half-bridge bit drives both low-side transistors in phase.
// - Six-bit burst pulse count; zero means continuous burst.
// - Sleep bit written one enters sleep, zero wakes.
// - Standby bit written one enters standby, zero leaves.
// - Charge trigger controls charging under auto-disable, unless supply high-impedance.
// - Burst trigger bit acts only in IO mode 0.
// - Status bit 3 shows drive supply at or above configured level.
// - Status bit 2 flags burst pulse count not received.
// - Status bit 1 flags driver stuck beyond deglitch time in burst.
// - Status bit 0 flags memory CRC failure.
// - Read-only identification register at address 0x1D.
// - Three-bit deglitch code: 64..4 us, code 7 disables check.
// - Auto-disable with trigger zero stops charging each time burst ends.
`timescale 1ns/1ps
`include "uedc_map.vh"

module uedc_regs #(
	parameter [7:0] PART_ID = 8'h5A // Arbitrary identification value
) (
	input  wire       clk_sys_in,
	input  wire       rst_n_in,

	// Register port from the serial interface decoder
	input  wire       reg_wr_in,
	input  wire       reg_rd_in,
	input  wire [7:0] reg_addr_in,
	input  wire [7:0] reg_wdata_in,
	output reg  [7:0] reg_rdata_out,

	// Settings held in registers outside this slice
	input  wire [1:0] io_mode_in,
	input  wire [2:0] deglitch_code_in,
	input  wire       listen_charge_auto_disable_in,
	input  wire       drive_supply_high_impedance_in,
	input  wire       envelope_output_scale_in,

	// Analog and pin inputs, asynchronous
	// Each passes two flip-flops before any logic reads it
	input  wire       echo_compare_raw_in,
	input  wire       zero_cross_raw_in,
	input  wire       drive_supply_ready_raw_in,
	input  wire       memory_crc_fault_raw_in,
	input  wire       burst_input_one_in,
	input  wire       burst_input_two_in,

	// Burst engine event, same clock
	// One-cycle pulse, so no synchroniser
	input  wire       burst_short_in,

	// Outputs to pins and analog blocks
	// All registered levels
	output reg        echo_interrupt_pin_out,
	output reg        zero_cross_pin_out,
	output reg  [3:0] echo_threshold_code_out,
	output reg        envelope_output_scale_out,
	output reg        zero_cross_enable_out,
	output reg        zero_cross_input_select_out,
	output reg  [1:0] zero_cross_stage_select_out,
	output reg  [2:0] zero_cross_hysteresis_out,
	output reg  [5:0] drive_current_limit_code_out,
	output reg        half_bridge_select_out,
	output reg  [5:0] burst_count_out,
	output reg        burst_continuous_out,
	output reg        sleep_out,
	output reg        standby_out,
	output reg        burst_enable_out,
	output reg        supply_charge_enable_out
);

	// Register copies, reserved bits already forced to zero
	reg  [7:0] echo_int_reg;
	reg  [7:0] zero_cross_reg;
	reg  [7:0] drv_clamp_reg;
	reg  [7:0] burst_len_reg;
	reg  [7:0] pwr_trig_reg;
	reg  [7:0] status_reg;

	// Synchroniser stages, bit order as in the concatenation below
	reg  [5:0] sync1_reg;
	reg  [5:0] sync2_reg;

	// History flops for edge detection and the charge state
	reg        io2_prev_reg;
	reg        burst_prev_reg;
	reg        charge_reg;
	// Read data before the output flop
	reg  [7:0] rdata_next;

	// Decoded second-stage levels and the timer event
	wire       burst_active;
	wire       stuck_event;
	wire       echo_sync;
	wire       zc_sync;
	wire       ready_sync;
	wire       crc_sync;
	wire       io1_sync;
	wire       io2_sync;

	// Two-flop synchronisers for all asynchronous levels. Nothing but the
	// second stage reads the first, so a metastable first stage can only
	// ever reach a flop that has a whole cycle to settle.
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_reg <= 6'h00;
			sync2_reg <= 6'h00;
		end else begin
			sync1_reg <= {burst_input_two_in, burst_input_one_in, memory_crc_fault_raw_in,
				drive_supply_ready_raw_in, zero_cross_raw_in, echo_compare_raw_in};
			sync2_reg <= sync1_reg;
		end
	end

	// Named taps on the second stage
	assign echo_sync  = sync2_reg[0];
	assign zc_sync    = sync2_reg[1];
	assign ready_sync = sync2_reg[2];
	assign crc_sync   = sync2_reg[3];
	assign io1_sync   = sync2_reg[4];
	assign io2_sync   = sync2_reg[5];

	// Burst runs from the command bit in IO mode 0, else from the pin.
	// In the pin modes the command bit is kept but ignored, so switching
	// back to mode 0 resumes with whatever was last written.
	assign burst_active = (io_mode_in == `UEDC_IO_MODE_0) ? pwr_trig_reg[`UEDC_BIT_BURST_TRIG]
		: io1_sync;

	// Register writes; masks keep reserved bits at zero
	// Masking on the way in, not on the way out, means every consumer of a
	// register copy already sees zero in reserved bits and needs no mask.
	// A write to the status, identity or an unmapped address changes nothing.
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			echo_int_reg   <= `UEDC_RST_ECHO_INT;
			zero_cross_reg <= `UEDC_RST_ZERO_CROSS;
			drv_clamp_reg  <= `UEDC_RST_DRV_CLAMP;
			burst_len_reg  <= `UEDC_RST_BURST_LEN;
			pwr_trig_reg   <= `UEDC_RST_PWR_TRIG;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				`UEDC_ADDR_ECHO_INT:   echo_int_reg   <= reg_wdata_in & `UEDC_WMASK_ECHO_INT;
				`UEDC_ADDR_ZERO_CROSS: zero_cross_reg <= reg_wdata_in & `UEDC_WMASK_ZERO_CROSS;
				`UEDC_ADDR_DRV_CLAMP:  drv_clamp_reg  <= reg_wdata_in & `UEDC_WMASK_DRV_CLAMP;
				`UEDC_ADDR_BURST_LEN:  burst_len_reg  <= reg_wdata_in & `UEDC_WMASK_BURST_LEN;
				`UEDC_ADDR_PWR_TRIG:   pwr_trig_reg   <= reg_wdata_in & `UEDC_WMASK_PWR_TRIG;
				default: ; // Status, identity and unmapped writes are dropped
			endcase
		end
	end

	// Stuck driver detection on the second burst input
	// The toggle term is the second stage xor its delayed copy, one cycle
	// per pin edge. Detection therefore lags the pin by three cycles, which
	// is far below the shortest deglitch time. The timer clears whenever
	// burst is inactive, so the pin level before a burst does not matter.
	uedc_stuck_timer u_stuck (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.active_in  (burst_active),
		.toggle_in  (io2_sync ^ io2_prev_reg),
		.code_in    (deglitch_code_in),
		.stuck_out  (stuck_event)
	);

	// Sticky faults; set wins, cleared only by reset since status is read-only
	// Bit 3 is live rather than sticky: the supply may sag and recover, and
	// software wants the present level. Bits 7:4 are reserved and held at zero.
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_reg     <= 8'h00;
			io2_prev_reg   <= 1'b0;
			burst_prev_reg <= 1'b0;
		end else begin
			io2_prev_reg   <= io2_sync;
			burst_prev_reg <= burst_active;
			status_reg[3]  <= ready_sync;
			status_reg[2]  <= status_reg[2] | burst_short_in;
			status_reg[1]  <= status_reg[1] | stuck_event;
			status_reg[0]  <= status_reg[0] | crc_sync;
			status_reg[7:4] <= 4'h0;
		end
	end

	// Supply charging: auto-disable drops it at each burst end unless
	// the trigger bit holds it on; high-impedance overrides everything.
	// Reset leaves charging off, so no one-cycle charge pulse can leave the
	// first edge while the supply is still high impedance; the cost is one
	// extra cycle before charging starts after reset. Under auto-disable, outside
	// bursts the state simply holds until the trigger bit or a new burst changes it.
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			charge_reg <= 1'b0;
		end else if (drive_supply_high_impedance_in) begin
			charge_reg <= 1'b0;
		end else if (listen_charge_auto_disable_in) begin
			if (pwr_trig_reg[`UEDC_BIT_CHG_TRIG]) begin
				charge_reg <= 1'b1;
			end else if (burst_prev_reg && !burst_active) begin
				charge_reg <= 1'b0;
			end else if (burst_active) begin
				charge_reg <= 1'b1;
			end
		end else begin
			// Without auto-disable the supply charges whenever not high impedance
			charge_reg <= 1'b1;
		end
	end

	// Read mux; unmapped addresses read zero
	// Decoding from the live address lets the strobe edge capture the data
	// directly, at the cost of a full mux on the address path.
	always @* begin
		case (reg_addr_in)
			`UEDC_ADDR_ECHO_INT:   rdata_next = echo_int_reg;
			`UEDC_ADDR_ZERO_CROSS: rdata_next = zero_cross_reg;
			`UEDC_ADDR_DRV_CLAMP:  rdata_next = drv_clamp_reg;
			`UEDC_ADDR_BURST_LEN:  rdata_next = burst_len_reg;
			`UEDC_ADDR_PWR_TRIG:   rdata_next = pwr_trig_reg;
			`UEDC_ADDR_STATUS:     rdata_next = status_reg;
			`UEDC_ADDR_PART_ID:    rdata_next = PART_ID;
			default:               rdata_next = 8'h00;
		endcase
	end

	// Registered outputs
	// Reset values match the register copies' reset values field by field
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out                <= 8'h00;
			echo_interrupt_pin_out       <= 1'b0;
			zero_cross_pin_out           <= 1'b0;
			echo_threshold_code_out      <= 4'h7;
			envelope_output_scale_out    <= 1'b0;
			zero_cross_enable_out        <= 1'b0;
			zero_cross_input_select_out  <= 1'b0;
			zero_cross_stage_select_out  <= 2'h2;
			zero_cross_hysteresis_out    <= 3'h4;
			drive_current_limit_code_out <= 6'h00;
			half_bridge_select_out       <= 1'b0;
			burst_count_out              <= 6'h00;
			burst_continuous_out         <= 1'b1;
			sleep_out                    <= 1'b0;
			standby_out                  <= 1'b0;
			burst_enable_out             <= 1'b0;
			supply_charge_enable_out     <= 1'b0;
		end else begin
			// Read data holds between reads
			if (reg_rd_in) begin
				reg_rdata_out <= rdata_next;
			end

			// Pins: two synchroniser edges plus this flop, three edges in all
			echo_interrupt_pin_out <= echo_sync & echo_int_reg[`UEDC_BIT_ECHO_EN];
			// Gating needs the raw comparator level, not the masked pin
			zero_cross_pin_out <= zero_cross_reg[`UEDC_BIT_ZC_EN] & zc_sync
				& (~zero_cross_reg[`UEDC_BIT_ZC_GATE] | echo_sync);

			// Comparator and zero-cross settings for the analog blocks
			echo_threshold_code_out      <= echo_int_reg[3:0];
			envelope_output_scale_out    <= envelope_output_scale_in;
			zero_cross_enable_out        <= zero_cross_reg[`UEDC_BIT_ZC_EN];
			zero_cross_input_select_out  <= zero_cross_reg[`UEDC_BIT_ZC_INSEL];
			zero_cross_stage_select_out  <= zero_cross_reg[4:3];
			zero_cross_hysteresis_out    <= zero_cross_reg[2:0];

			// Drive and burst settings
			drive_current_limit_code_out <= drv_clamp_reg[5:0];
			half_bridge_select_out       <= burst_len_reg[`UEDC_BIT_HALF_BRG];
			burst_count_out              <= burst_len_reg[5:0];
			burst_continuous_out         <= (burst_len_reg[5:0] == 6'h00);

			// Power modes, burst enable and supply charging
			sleep_out                    <= pwr_trig_reg[`UEDC_BIT_SLEEP];
			standby_out                  <= pwr_trig_reg[`UEDC_BIT_STANDBY];
			burst_enable_out             <= burst_active;
			supply_charge_enable_out     <= charge_reg;
		end
	end

endmodule // uedc_regs

// file: uedc_regs_properties.sv
// Port-level checker for the echo/drive control register slice.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module uedc_regs_properties (
	input wire       clk_sys_in,
	input wire       rst_n_in,
	input wire       reg_wr_in,
	input wire       reg_rd_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire [7:0] reg_rdata_out,
	input wire [1:0] io_mode_in,
	input wire       burst_input_one_in,
	input wire       drive_supply_high_impedance_in,
	input wire       echo_compare_raw_in,
	input wire       echo_interrupt_pin_out,
	input wire       zero_cross_pin_out,
	input wire [5:0] burst_count_out,
	input wire       burst_continuous_out,
	input wire       sleep_out,
	input wire       burst_enable_out,
	input wire       supply_charge_enable_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// Write decodes; derived outputs follow two edges after the write is taken
	wire w17 = reg_wr_in && reg_addr_in == 8'h17;
	wire w18 = reg_wr_in && reg_addr_in == 8'h18;
	wire w1a = reg_wr_in && reg_addr_in == 8'h1A;
	wire w1b = reg_wr_in && reg_addr_in == 8'h1B;
	a_echo_pin_cause: assert property (echo_interrupt_pin_out |-> $past(echo_compare_raw_in, 3))
		else $error("echo pin high without a comparator cause");
	a_echo_mask_off: assert property (w17 && !reg_wdata_in[4] |-> ##2 !echo_interrupt_pin_out)
		else $error("echo pin not masked after enable cleared");
	a_zc_enable_off: assert property (w18 && !reg_wdata_in[7] |-> ##2 !zero_cross_pin_out)
		else $error("zero-cross pin active while disabled");
	a_continuous_zero: assert property (burst_continuous_out == (burst_count_out == 6'h00))
		else $error("continuous flag disagrees with pulse count");
	a_count_update: assert property (w1a |-> ##2 {2'h0, burst_count_out} == ($past(reg_wdata_in, 2) & 8'h3F))
		else $error("pulse count not taken from write");
	a_sleep_update: assert property (w1b |-> ##2 sleep_out == ($past(reg_wdata_in, 2) >= 8'h80))
		else $error("sleep output not taken from write");
	a_charge_hiz_off: assert property (drive_supply_high_impedance_in [*3] |-> !supply_charge_enable_out)
		else $error("charging enabled while supply high impedance");
	a_burst_other_mode: assert property ((io_mode_in != 2'h0 && !burst_input_one_in) [*5] |-> !burst_enable_out)
		else $error("burst enabled by register outside mode zero");
	a_read_unmapped: assert property (reg_rd_in && (reg_addr_in < 8'h17 || reg_addr_in > 8'h1D) |=> reg_rdata_out == 8'h00)
		else $error("unmapped read returned nonzero");
	// Main scenarios reached
	cover property (echo_interrupt_pin_out);
	cover property ($fell(burst_continuous_out));
	cover property ($rose(sleep_out));
endmodule // uedc_regs_properties

// file: uedc_host_model.sv
// Microcontroller side of the register port: single-byte transfers only.
// Assumes each task is entered just after a falling clock edge.
`timescale 1ns/1ps
module uedc_host_model (
	input  wire       clk_sys_in,
	input  wire [7:0] reg_rdata_in,
	output reg        reg_wr_out,
	output reg        reg_rd_out,
	output reg  [7:0] reg_addr_out,
	output reg  [7:0] reg_wdata_out
);
	// Idle bus; address and data are junk so stale values are never trusted
	initial begin
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = 8'hA5;
		reg_wdata_out = 8'h5A;
	end
	// Write: strobe spans one rising edge, then one idle edge before the next use
	task wr(input [7:0] a, input [7:0] d);
	begin
		reg_addr_out = a;
		reg_wdata_out = d;
		reg_wr_out = 1'b1;
		@(negedge clk_sys_in);
		reg_wr_out = 1'b0;
		reg_addr_out = ~a;
		reg_wdata_out = ~d;
		@(negedge clk_sys_in);
	end
	endtask
	// Read: data is registered on the taking edge, so it is settled by the next fall
	task rd(input [7:0] a, output [7:0] d);
	begin
		reg_addr_out = a;
		reg_rd_out = 1'b1;
		@(negedge clk_sys_in);
		reg_rd_out = 1'b0;
		reg_addr_out = ~a;
		d = reg_rdata_in;
		@(negedge clk_sys_in);
	end
	endtask
endmodule // uedc_host_model

// file: test_ultrasonic_echo_drive_control_regs.sv
// Self-checking bench for the echo/drive register slice, driven by a host model.
// Assumes a 200 MHz clock; every input changes on the falling edge.
`timescale 1ns/1ps
module test_ultrasonic_echo_drive_control_regs;
	localparam [7:0] ID = 8'h3C; // Arbitrary identification value
	reg        clk_sys_in = 1'b0;
	reg        rst_n_in = 1'b0;
	reg  [1:0] iom = 2'h0;
	reg  [2:0] dg = 3'h7;
	reg        ad = 1'b0, hiz = 1'b1, sc = 1'b0, er = 1'b0, zr = 1'b0;
	reg        rdy = 1'b0, crc = 1'b0, io1 = 1'b0, io2 = 1'b0, sh = 1'b0;
	reg  [7:0] m [0:255];
	reg  [7:0] stat = 8'h00, rv, a;
	reg [15:0] rnd = 16'h952D;
	integer    failures = 0, checked = 0, cycles = 0, i, k;
	wire       wr, rd, ep, zp, so, ze, zs, hb, ct, sl, sb, be, ch;
	wire [7:0] ad_w, wd, rdat;
	wire [3:0] th;
	wire [2:0] zh;
	wire [1:0] zg;
	wire [5:0] il, cn;
	// Clock
	always #2.5 clk_sys_in = ~clk_sys_in;
	uedc_host_model host (.clk_sys_in(clk_sys_in), .reg_rdata_in(rdat), .reg_wr_out(wr), .reg_rd_out(rd),
		.reg_addr_out(ad_w), .reg_wdata_out(wd));
	uedc_regs #(.PART_ID(ID)) dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(ad_w), .reg_wdata_in(wd), .reg_rdata_out(rdat), .io_mode_in(iom), .deglitch_code_in(dg),
		.listen_charge_auto_disable_in(ad), .drive_supply_high_impedance_in(hiz), .envelope_output_scale_in(sc),
		.echo_compare_raw_in(er), .zero_cross_raw_in(zr), .drive_supply_ready_raw_in(rdy),
		.memory_crc_fault_raw_in(crc), .burst_input_one_in(io1), .burst_input_two_in(io2), .burst_short_in(sh),
		.echo_interrupt_pin_out(ep), .zero_cross_pin_out(zp), .echo_threshold_code_out(th),
		.envelope_output_scale_out(so), .zero_cross_enable_out(ze), .zero_cross_input_select_out(zs),
		.zero_cross_stage_select_out(zg), .zero_cross_hysteresis_out(zh), .drive_current_limit_code_out(il),
		.half_bridge_select_out(hb), .burst_count_out(cn), .burst_continuous_out(ct), .sleep_out(sl),
		.standby_out(sb), .burst_enable_out(be), .supply_charge_enable_out(ch));
	// Pseudo-random source and register model
	function [15:0] lfsr(input [15:0] s);
		lfsr = {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
	endfunction
	function [7:0] msk(input [7:0] x);
		case (x)
			8'h17: msk = 8'h1F;
			8'h18: msk = 8'hFF;
			8'h19: msk = 8'h3F;
			8'h1A: msk = 8'hBF;
			8'h1B: msk = 8'hC3;
			default: msk = 8'h00;
		endcase
	endfunction
	function [7:0] exp_rd(input [7:0] x);
		exp_rd = (x == 8'h1C) ? stat : (x == 8'h1D) ? ID : m[x] & msk(x);
	endfunction
	task chk(input [31:0] seen, input [31:0] exp);
	begin
		checked = checked + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task tally_and_finish;
	begin
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	// Reset pulse of n cycles; the model returns to its reset contents
	task rst_seq(input integer n);
	begin
		rst_n_in = 1'b0;
		for (i = 0; i < 256; i = i + 1) m[i] = 8'h00;
		m[8'h17] = 8'h07;
		m[8'h18] = 8'h14;
		stat = 8'h00;
		cyc(n);
		rst_n_in = 1'b1;
		cyc(1);
	end
	endtask
	// Deglitch limits in 5 ns cycles: 64, 48, 32, 24, 16, 8 and 4 us
	function integer dt_cyc(input integer c);
		case (c)
			0: dt_cyc = 64 * 200;
			1: dt_cyc = 48 * 200;
			2: dt_cyc = 32 * 200;
			3: dt_cyc = 24 * 200;
			4: dt_cyc = 16 * 200;
			5: dt_cyc = 8 * 200;
			default: dt_cyc = 4 * 200;
		endcase
	endfunction
	task wrm(input [7:0] x, input [7:0] d);
	begin
		host.wr(x, d);
		m[x] = d & msk(x);
	end
	endtask
	task rdc(input [7:0] x);
	begin
		host.rd(x, rv);
		chk(rv, exp_rd(x));
	end
	endtask
	// Configuration outputs against the model
	task outs;
	begin
		chk({th, so}, {m[8'h17][3:0], sc});
		chk({ze, zs, zg, zh}, {m[8'h18][7], m[8'h18][5:0]});
		chk(il, m[8'h19][5:0]);
		chk({hb, cn, ct}, {m[8'h1A][7], m[8'h1A][5:0], m[8'h1A][5:0] == 6'h00});
		chk({sl, sb}, m[8'h1B][7:6]);
		chk(be, iom == 2'h0 ? m[8'h1B][0] : io1);
		chk(ch, !hiz);
	end
	endtask
	// Hang guard
	always @(posedge clk_sys_in) begin
		cycles = cycles + 1;
		if (cycles == 50000) begin
			failures = failures + 1;
			tally_and_finish;
		end
	end
	// Main sequence
	initial begin
		rst_seq(10);
		for (i = 8'h15; i < 8'h1F; i = i + 1) rdc(i[7:0]);
		outs;
		for (k = 0; k < 48; k = k + 1) begin
			rnd = lfsr(rnd);
			{sc, hiz, io1, iom} = rnd[4:0];
			rnd = lfsr(rnd);
			a = 8'h16 + {4'h0, rnd[3:0]} % 8'h09;
			rnd = lfsr(rnd);
			wrm(a, rnd[7:0]);
			rdc(a);
			outs;
		end
		// Pin masking and zero-cross gating over every combination
		for (i = 0; i < 32; i = i + 1) begin
			er = i[0];
			zr = i[1];
			wrm(8'h18, {i[2], i[3], 6'h14});
			wrm(8'h17, {3'h0, i[4], 4'h7});
			cyc(3);
			chk(ep, i[0] & i[4]);
			chk(zp, i[2] & i[1] & (!i[3] | i[0]));
		end
		// Sticky faults survive their cause; supply ready is live
		rdy = 1'b1; crc = 1'b1; sh = 1'b1;
		cyc(1);
		sh = 1'b0;
		cyc(3);
		crc = 1'b0;
		cyc(4);
		stat = 8'h0D;
		rdc(8'h1C);
		rdy = 1'b0;
		wrm(8'h1C, 8'hFF);
		cyc(2);
		stat = 8'h05;
		rdc(8'h1C);
		// Stuck driver: disabled code first, then the 4 us limit
		iom = 2'h0;
		wrm(8'h1B, 8'h01);
		cyc(900);
		rdc(8'h1C);
		io2 = ~io2; dg = 3'h6;
		cyc(770);
		rdc(8'h1C);
		cyc(60);
		stat = 8'h07;
		rdc(8'h1C);
		// Charging under auto-disable follows burst, then the trigger bit
		hiz = 1'b0; ad = 1'b1;
		cyc(4);
		chk(ch, 1'b1);
		wrm(8'h1B, 8'h00);
		cyc(3);
		chk(ch, 1'b0);
		wrm(8'h1B, 8'h02);
		cyc(3);
		chk(ch, 1'b1);
		// Deglitch codes 0 to 6: a mid-run reset clears the sticky flag, then the limit is bracketed
		for (k = 0; k < 7; k = k + 1) begin
			rst_seq(2);
			rdc(8'h18);
			iom = 2'h0;
			dg = k[2:0];
			wrm(8'h1B, 8'h01);
			io2 = ~io2;
			cyc(dt_cyc(k) - 40);
			rdc(8'h1C);
			cyc(80);
			stat = 8'h02;
			rdc(8'h1C);
		end
		tally_and_finish;
	end
endmodule // test_ultrasonic_echo_drive_control_regs
bind uedc_regs uedc_regs_properties chk_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
	.io_mode_in(io_mode_in), .burst_input_one_in(burst_input_one_in),
	.drive_supply_high_impedance_in(drive_supply_high_impedance_in), .echo_compare_raw_in(echo_compare_raw_in),
	.echo_interrupt_pin_out(echo_interrupt_pin_out), .zero_cross_pin_out(zero_cross_pin_out),
	.burst_count_out(burst_count_out), .burst_continuous_out(burst_continuous_out), .sleep_out(sleep_out),
	.burst_enable_out(burst_enable_out), .supply_charge_enable_out(supply_charge_enable_out));
